// ### rtl/pswl_pkg.sv
// Constants and types of the power state and wake logic.
package pswl_pkg;

    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PM_CTRL  = 8'h00;
    localparam logic [7:0] OFF_WAKE     = 8'h04;
    localparam logic [7:0] OFF_CMD      = 8'h08;
    localparam logic [7:0] OFF_MAC_LO   = 8'h0c;
    localparam logic [7:0] OFF_MAC_HI   = 8'h10;
    localparam logic [7:0] OFF_PAT_ADDR = 8'h14;
    localparam logic [7:0] OFF_PAT_DATA = 8'h18;
    localparam logic [7:0] OFF_PAT_BASE = 8'h1c;

    localparam int PM_EN_BIT   = 8;
    localparam int PM_PEND_BIT = 15;
    localparam int WK_FLAG_POS = 8;
    localparam int WK_LINK_POS = 16;
    localparam int CMD_ST_POS  = 4;
    localparam int EE_LIGHT_BIT   = 9;
    localparam int EE_PARTIAL_BIT = 10;

    // Cause indices: enables [3:0], flags [2:0].
    localparam int CE_PAT  = 0;
    localparam int CE_REP  = 1;
    localparam int CE_LINK = 2;
    localparam int CE_RWM  = 3;

    localparam logic [2:0] CMD_ALL = 3'h7;
    localparam logic [1:0] PS_FULL    = 2'h0;
    localparam logic [1:0] PS_LIGHT   = 2'h1;
    localparam logic [1:0] PS_PARTIAL = 2'h2;
    localparam logic [1:0] PS_OFF     = 2'h3;

    // ------------------------------------------------------------
    // Matching constants
    // ------------------------------------------------------------
    localparam int PAT_PTR_W = 8;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [2:0] SYNC_LEN = 3'h6;
    localparam logic [2:0] ADDR_LAST = 3'h5;
    localparam logic [3:0] REP_LAST = 4'hf;

    typedef logic [PAT_PTR_W-1:0] pswl_ptr_t;
    localparam pswl_ptr_t PTR_ONE = pswl_ptr_t'(1);

    typedef enum logic [2:0] {
        FULL_POWER_UNCONFIGURED, FULL_POWER_ACTIVE, LIGHT_SLEEP_STATE,
        PARTIAL_SLEEP_STATE, HOT_OFF_STATE
    } pswl_state_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic       filter_ok;
        logic       addr_ok;
        logic [7:0] data;
    } pswl_rx_t;

    typedef struct packed {
        logic cfg_ok;
        logic io_ok;
        logic mem_ok;
        logic master_ok;
    } pswl_gate_t;

    typedef struct packed {
        logic [7:0]  skip;
        logic [7:0]  take;
        pswl_ptr_t   ptr;
        logic        done;
        logic [31:0] crc;
    } pswl_lane_t;

    localparam pswl_lane_t LANE_IDLE = '0;

endpackage

// ### rtl/pswl_core.sv
// Power state machine, PCI cycle gating and wake event detection.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module pswl_core
    import pswl_pkg::*;
#(
    parameter int NUM_LANES = 2
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        aux_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        forced_config,
    input  wire logic [15:0] eeprom_config_word,
    input  wire pswl_rx_t    rx,
    input  wire logic        link_up,
    output pswl_gate_t       pci_gate,
    output logic             pm_event_pin_n_o,
    output logic             pm_event_pin_n_oe
);

    localparam int PAT_DEPTH = 1 << PAT_PTR_W;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    pswl_state_t state_reg, state_next;
    logic        boot_reg;
    logic [2:0]  cmd_reg, cmd_next;
    logic        wake_en_reg, wake_en_next;
    logic        pend_reg, pend_next;
    logic [3:0]  cause_en_reg, cause_en_next;
    logic [2:0]  flag_reg, flag_next;
    logic        link_ref_reg;
    logic [47:0] mac_reg;
    logic [7:0]  pat_mem [PAT_DEPTH];
    pswl_ptr_t   pat_wptr_reg;
    pswl_ptr_t   pat_base_reg [NUM_LANES];
    pswl_lane_t  lane_reg [NUM_LANES];
    pswl_lane_t  lane_nx [NUM_LANES];
    logic [NUM_LANES-1:0] lane_hit;
    logic [2:0]  sync_reg, sync_next;
    logic [2:0]  idx_reg, idx_next;
    logic [3:0]  rep_reg, rep_next;
    logic        found_reg, found_next;
    logic [31:0] rdata_reg, rdata_next;
    pswl_gate_t  gate_reg, gate_next;
    logic        pin_oe_reg;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // One byte of the reflected Ethernet CRC, low bit first.
    function automatic logic [31:0] crc_byte(
        input logic [31:0] c,
        input logic [7:0]  b
    );
        logic [31:0] r;
        r = c;
        for (int k = 0; k < 8; k++) begin
            if (r[0] ^ b[k]) begin
                r = (r >> 1) ^ CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    // Loads the offset/count pair at the lane pointer.
    function automatic pswl_lane_t lane_load(input pswl_lane_t c);
        pswl_lane_t n;
        n = c;
        if (pat_mem[c.ptr] == 8'h00) begin
            n.done = 1'b1;
        end else begin
            n.skip = pat_mem[c.ptr];
            n.take = pat_mem[c.ptr + PTR_ONE];
            n.ptr  = c.ptr + PTR_ONE + PTR_ONE;
        end
        return n;
    endfunction

    // Advances a lane by one received byte.
    function automatic pswl_lane_t lane_step(
        input pswl_lane_t c,
        input logic [7:0] b
    );
        pswl_lane_t n;
        n = c;
        if (c.done) begin
            n = c;
        end else if (c.skip != 8'h00) begin
            n.skip = c.skip - 8'h01;
        end else if (c.take != 8'h00) begin
            n.crc  = crc_byte(c.crc, b);
            n.take = c.take - 8'h01;
            if (c.take == 8'h01) begin
                n = lane_load(n);
            end
        end
        return n;
    endfunction

    // Stored CRC sits right after the terminator, low byte first.
    function automatic logic [31:0] pat_crc(input pswl_ptr_t p);
        pswl_ptr_t q;
        q = p + PTR_ONE;
        return {pat_mem[q + PTR_ONE + PTR_ONE + PTR_ONE],
                pat_mem[q + PTR_ONE + PTR_ONE],
                pat_mem[q + PTR_ONE], pat_mem[q]};
    endfunction

    // Byte of the own address in wire order, first byte on top.
    function automatic logic [7:0] mac_byte(input logic [2:0] i);
        return mac_reg[8'(47 - 8 * int'(i)) -: 8];
    endfunction

    // Two-bit power code of a state.
    function automatic logic [1:0] state_code(input pswl_state_t s);
        case (s)
            LIGHT_SLEEP_STATE:   return PS_LIGHT;
            PARTIAL_SLEEP_STATE: return PS_PARTIAL;
            HOT_OFF_STATE:       return PS_OFF;
            default: return PS_FULL;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire logic wr_pm   = reg_wr && (reg_addr == OFF_PM_CTRL);
    wire logic wr_wake = reg_wr && (reg_addr == OFF_WAKE);
    wire logic wr_cmd  = reg_wr && (reg_addr == OFF_CMD);
    wire logic wr_mlo  = reg_wr && (reg_addr == OFF_MAC_LO);
    wire logic wr_mhi  = reg_wr && (reg_addr == OFF_MAC_HI);
    wire logic wr_padr = reg_wr && (reg_addr == OFF_PAT_ADDR);
    wire logic wr_pdat = reg_wr && (reg_addr == OFF_PAT_DATA);
    wire logic wr_pbas = reg_wr && (reg_addr == OFF_PAT_BASE);
    wire logic [1:0] ps_wr = reg_wdata[1:0];
    wire logic light_ok   = eeprom_config_word[EE_LIGHT_BIT];
    wire logic partial_ok = eeprom_config_word[EE_PARTIAL_BIT];
    wire logic asleep = (state_reg == LIGHT_SLEEP_STATE)
                     || (state_reg == PARTIAL_SLEEP_STATE)
                     || (state_reg == HOT_OFF_STATE);
    wire logic active = (state_reg == FULL_POWER_ACTIVE);
    wire logic rx_end = rx.valid && rx.last;

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------

    // Implicit moves first, then a power-state write overrides.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FULL_POWER_UNCONFIGURED: begin
                if (boot_reg && (forced_config || cause_en_reg[CE_RWM])) begin
                    state_next = FULL_POWER_ACTIVE;
                end else if (cmd_reg == CMD_ALL) begin
                    state_next = FULL_POWER_ACTIVE;
                end
            end
            FULL_POWER_ACTIVE: begin
                if (cmd_reg != CMD_ALL && !boot_reg) begin
                    state_next = FULL_POWER_ACTIVE;
                end
            end
            LIGHT_SLEEP_STATE, PARTIAL_SLEEP_STATE,
            HOT_OFF_STATE: state_next = state_reg;
            default: state_next = FULL_POWER_UNCONFIGURED;
        endcase
        if (wr_pm) begin
            case (ps_wr)
                PS_FULL: begin
                    if (state_reg == HOT_OFF_STATE) begin
                        state_next = FULL_POWER_UNCONFIGURED;
                    end else if (asleep) begin
                        state_next = (cmd_reg == CMD_ALL)
                                   ? FULL_POWER_ACTIVE
                                   : FULL_POWER_UNCONFIGURED;
                    end
                end
                PS_LIGHT: begin
                    if (light_ok) begin
                        state_next = LIGHT_SLEEP_STATE;
                    end
                end
                PS_PARTIAL: begin
                    if (partial_ok) begin
                        state_next = PARTIAL_SLEEP_STATE;
                    end
                end
                default: state_next = HOT_OFF_STATE;
            endcase
        end
    end

    // Command enables; hot-off entry wipes them.
    always_comb begin
        cmd_next = wr_cmd ? reg_wdata[2:0] : cmd_reg;
        if (state_next == HOT_OFF_STATE && state_reg != HOT_OFF_STATE) begin
            cmd_next = 3'h0;
        end
    end

    // State, boot marker and command register.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= FULL_POWER_UNCONFIGURED;
            boot_reg  <= 1'b1;
            cmd_reg   <= 3'h0;
        end else begin
            state_reg <= state_next;
            boot_reg  <= 1'b0;
            cmd_reg   <= cmd_next;
        end
    end

    // ------------------------------------------------------------
    // PCI cycle gating
    // ------------------------------------------------------------

    // Configuration always answered; I/O, memory, master only when active.
    always_comb begin
        gate_next.cfg_ok    = 1'b1;
        gate_next.io_ok     = active && cmd_reg[0];
        gate_next.mem_ok    = active && cmd_reg[1];
        gate_next.master_ok = active && cmd_reg[2];
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gate_reg <= '0;
        end else begin
            gate_reg <= gate_next;
        end
    end

    // ------------------------------------------------------------
    // Pattern store and match lanes
    // ------------------------------------------------------------

    // Software fills the store byte by byte through the data port.
    always_ff @(posedge mclk) begin
        if (wr_pdat) begin
            pat_mem[pat_wptr_reg] <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pat_wptr_reg <= '0;
        end else if (wr_padr) begin
            pat_wptr_reg <= reg_wdata[PAT_PTR_W-1:0];
        end else if (wr_pdat) begin
            pat_wptr_reg <= pat_wptr_reg + PTR_ONE;
        end
    end

    // Each lane walks one pattern; the first byte restarts it.
    always_comb begin
        lane_hit = '0;
        for (int i = 0; i < NUM_LANES; i++) begin
            lane_nx[i] = lane_reg[i];
            if (rx.valid && rx.first) begin
                lane_nx[i] = LANE_IDLE;
                lane_nx[i].ptr = pat_base_reg[i];
                lane_nx[i].crc = CRC_INIT;
                lane_nx[i] = lane_load(lane_nx[i]);
            end
            if (rx.valid) begin
                lane_nx[i] = lane_step(lane_nx[i], rx.data);
            end
            lane_hit[i] = lane_nx[i].done
                       && (~lane_nx[i].crc == pat_crc(lane_nx[i].ptr));
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < NUM_LANES; i++) begin
            if (sys_rst) begin
                lane_reg[i]     <= LANE_IDLE;
                pat_base_reg[i] <= '0;
            end else begin
                lane_reg[i] <= rx_end ? LANE_IDLE : lane_nx[i];
                if (wr_pbas) begin
                    pat_base_reg[i] <= reg_wdata[8*i +: PAT_PTR_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Repeated-address search
    // ------------------------------------------------------------

    // Sync run of 0xff, then sixteen address copies back to back.
    always_comb begin
        sync_next  = sync_reg;
        idx_next   = idx_reg;
        rep_next   = rep_reg;
        found_next = found_reg;
        if (rx.valid && !found_reg) begin
            if (sync_reg != SYNC_LEN) begin
                sync_next = (rx.data == 8'hff) ? sync_reg + 3'h1 : 3'h0;
            end else if (rx.data == mac_byte(idx_reg)) begin
                idx_next = (idx_reg == ADDR_LAST) ? 3'h0 : idx_reg + 3'h1;
                if (idx_reg == ADDR_LAST) begin
                    rep_next   = rep_reg + 4'h1;
                    found_next = (rep_reg == REP_LAST);
                end
            end else if (rx.data == 8'hff && rep_reg == 4'h0
                         && idx_reg == 3'h0) begin
                sync_next = SYNC_LEN;
            end else begin
                idx_next  = 3'h0;
                rep_next  = 4'h0;
                sync_next = (rx.data == 8'hff) ? 3'h1 : 3'h0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || rx_end) begin
            sync_reg  <= 3'h0;
            idx_reg   <= 3'h0;
            rep_reg   <= 4'h0;
            found_reg <= 1'b0;
        end else begin
            sync_reg  <= sync_next;
            idx_reg   <= idx_next;
            rep_reg   <= rep_next;
            found_reg <= found_next;
        end
    end

    // ------------------------------------------------------------
    // Wake causes, flags and pending status
    // ------------------------------------------------------------
    wire logic pat_evt = rx_end && rx.filter_ok && (|lane_hit)
                      && asleep && cause_en_reg[CE_PAT];
    wire logic rep_evt = rx_end && rx.addr_ok && found_next
                      && asleep && cause_en_reg[CE_REP];
    wire logic lnk_evt = asleep && cause_en_reg[CE_LINK]
                      && (link_up != link_ref_reg);
    wire logic [2:0] evt = {lnk_evt, rep_evt, pat_evt};
    wire logic [2:0] flag_clr = wr_wake ? reg_wdata[WK_FLAG_POS +: 3]
                                        : 3'h0;
    wire logic pend_clr = wr_pm && reg_wdata[PM_PEND_BIT];
    wire logic link_arm = wr_wake && reg_wdata[CE_LINK]
                       && !cause_en_reg[CE_LINK];

    // A cause in the clearing cycle survives the clear.
    always_comb begin
        flag_next     = (flag_reg & ~flag_clr) | evt;
        pend_next     = (pend_reg && !pend_clr)
                     || (wake_en_reg && (|evt));
        wake_en_next  = wr_pm ? reg_wdata[PM_EN_BIT] : wake_en_reg;
        cause_en_next = wr_wake ? reg_wdata[3:0] : cause_en_reg;
    end

    // Wake context survives a bus reset; only the aux reset clears it.
    always_ff @(posedge mclk) begin
        if (aux_rst) begin
            wake_en_reg  <= 1'b0;
            pend_reg     <= 1'b0;
            cause_en_reg <= 4'h0;
            flag_reg     <= 3'h0;
            link_ref_reg <= 1'b0;
            pin_oe_reg   <= 1'b0;
        end else begin
            wake_en_reg  <= wake_en_next;
            pend_reg     <= pend_next;
            cause_en_reg <= cause_en_next;
            flag_reg     <= flag_next;
            pin_oe_reg   <= wake_en_next && pend_next;
            if (link_arm) begin
                link_ref_reg <= link_up;
            end
        end
    end

    // ------------------------------------------------------------
    // Address and read-back
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mac_reg <= 48'h0;
        end else if (wr_mlo) begin
            mac_reg[31:0] <= reg_wdata;
        end else if (wr_mhi) begin
            mac_reg[47:32] <= reg_wdata[15:0];
        end
    end

    // Read data for the addressed register; unmapped reads give zero.
    always_comb begin
        rdata_next = 32'h0;
        case (reg_addr)
            OFF_PM_CTRL: begin
                rdata_next[1:0]         = state_code(state_reg);
                rdata_next[PM_EN_BIT]   = wake_en_reg;
                rdata_next[PM_PEND_BIT] = pend_reg;
            end
            OFF_WAKE: begin
                rdata_next[3:0]              = cause_en_reg;
                rdata_next[WK_FLAG_POS +: 3] = flag_reg;
                rdata_next[WK_LINK_POS]      = link_up;
            end
            OFF_CMD: begin
                rdata_next[2:0]            = cmd_reg;
                rdata_next[CMD_ST_POS +: 3] = state_reg;
            end
            OFF_MAC_LO:   rdata_next = mac_reg[31:0];
            OFF_MAC_HI:   rdata_next[15:0] = mac_reg[47:32];
            OFF_PAT_ADDR: rdata_next[PAT_PTR_W-1:0] = pat_wptr_reg;
            default:      rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= reg_rd ? rdata_next : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // The event pin is open drain: it only ever pulls low.
    always_ff @(posedge mclk) begin
        pm_event_pin_n_o <= 1'b0;
    end

    assign reg_rdata         = rdata_reg;
    assign pci_gate          = gate_reg;
    assign pm_event_pin_n_oe = pin_oe_reg;

endmodule

`default_nettype wire

// ### sim/pswl_core_chk.sv
// Checker of the power state and wake logic ports.
`timescale 1ns/10ps
`default_nettype none
module pswl_chk
    import pswl_pkg::*;
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        aux_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic [15:0] eeprom_config_word,
    input wire pswl_rx_t    rx,
    input wire logic        link_up,
    input wire pswl_gate_t  pci_gate,
    input wire logic        pm_event_pin_n_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst || aux_rst);
    // Decoded writes to the power control and command registers.
    wire logic pm_wr = reg_wr && reg_addr == OFF_PM_CTRL;
    wire logic cmd_wr = reg_wr && reg_addr == OFF_CMD;
    sequence s_cmd_clear;
        cmd_wr && !reg_wdata[0] ##1 !cmd_wr;
    endsequence
    sequence s_off_wr;
        pm_wr && reg_wdata[1:0] == PS_OFF ##1 !reg_wr;
    endsequence
    sequence s_light_ign;
        pci_gate.io_ok && !$past(reg_wr) && pm_wr
            && reg_wdata[1:0] == PS_LIGHT
            && !eeprom_config_word[EE_LIGHT_BIT] ##1 !reg_wr;
    endsequence
    AST_RESET_GATE: assert property (disable iff (aux_rst)
        $fell(sys_rst) |=> pci_gate == 4'h8) else $error("reset gate");
    AST_CFG_ON: assert property ($past(!sys_rst) |-> pci_gate.cfg_ok)
        else $error("config refused");
    AST_CMD_CLR: assert property (s_cmd_clear |=> !pci_gate.io_ok)
        else $error("io open without enable");
    AST_OFF_GATE: assert property (s_off_wr |=> pci_gate == 4'h8)
        else $error("off state gate");
    AST_LIGHT_UNSUP: assert property (s_light_ign |=> pci_gate.io_ok)
        else $error("unsupported light sleep taken");
    AST_PIN_CLEAR: assert property (pm_wr && !reg_wdata[PM_EN_BIT]
        |=> !pm_event_pin_n_oe) else $error("pin held");
    AST_NO_WAKE_FULL: assert property (pci_gate.io_ok
        |-> !$rose(pm_event_pin_n_oe)) else $error("wake at full power");
    AST_CAUSE_PIN: assert property ($rose(pm_event_pin_n_oe)
        |-> $past(rx.valid && rx.last) || $past(reg_wr)
            || $past(link_up, 1) != $past(link_up, 4))
        else $error("pin without cause");
endmodule
bind pswl_core pswl_chk pswl_chk_i (.mclk, .sys_rst, .aux_rst, .reg_addr,
    .reg_wdata, .reg_wr, .eeprom_config_word, .rx, .link_up, .pci_gate,
    .pm_event_pin_n_oe);
`default_nettype wire

// ### sim/pswl_net.sv
// Network side model that feeds received bytes and the link state.
`timescale 1ns/10ps
`default_nettype none
module pswl_net
    import pswl_pkg::*;
(
    input wire logic mclk,
    output pswl_rx_t rx,
    output logic     link_up
);
    // Idle receive lane and an established link at start.
    initial begin
        rx = '0;
        link_up = 1'b1;
    end
    // Sends a frame a byte per clock, then leaves changed idle data.
    task automatic send(input logic [7:0] q[$], input logic ok);
        for (int i = 0; i < q.size(); i++) begin
            rx <= '{1'b1, i == 0, i == q.size() - 1, ok, ok, q[i]};
            @(posedge mclk);
        end
        rx <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~q[q.size() - 1]};
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ### sim/pswl_core_tb.sv
// Self-checking testbench of the power state and wake logic.
`timescale 1ns/10ps
`default_nettype none
module pswl_core_tb
    import pswl_pkg::*;
;
    localparam logic [47:0] MACV = 48'h021122334455;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        aux_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        forced_config = 1'b0;
    logic [15:0] eeprom_config_word = 16'h0;
    logic [31:0] reg_rdata;
    pswl_rx_t    rx;
    logic        link_up;
    pswl_gate_t  pci_gate;
    logic        pin_o;
    logic        pin_oe;
    logic [7:0]  mq[$];
    int          error_cnt = 0;
    int          n_checks = 0;
    // Clock of 25 ns period.
    always #12.5 mclk = ~mclk;
    // Block under test and the network side model.
    pswl_core pswl_core_i (.mclk, .sys_rst, .aux_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .forced_config,
        .eeprom_config_word, .rx, .link_up, .pci_gate,
        .pm_event_pin_n_o(pin_o), .pm_event_pin_n_oe(pin_oe));
    pswl_net pswl_net_i (.mclk, .rx, .link_up);
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("rdata_%h", a), reg_rdata & m, e);
        @(posedge mclk);
    endtask
    task automatic pins(input logic [3:0] g, input logic oe);
        @(posedge mclk);
        @(negedge mclk);
        chk("gate_pin", {26'h0, pci_gate, pin_oe, pin_o},
            {26'h0, g, oe, 1'b0});
        @(posedge mclk);
    endtask
    function automatic logic [31:0] crc(input logic [7:0] b[$]);
        logic [31:0] c;
        c = CRC_INIT;
        foreach (b[i]) begin
            c ^= {24'h0, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction
    task automatic t_reset;
        pins(4'h8, 1'b0);
        rc(OFF_CMD, 32'h70, 32'h0);
        rc(OFF_PM_CTRL, 32'h3, 32'h0);
    endtask
    task automatic t_active;
        wr(OFF_CMD, 32'h7);
        pins(4'hf, 1'b0);
        wr(OFF_CMD, 32'h0);
        pins(4'h8, 1'b0);
        rc(OFF_CMD, 32'h70, 32'h10);
        wr(OFF_CMD, 32'h7);
        wr(OFF_WAKE, 32'h2);
        wr(OFF_PM_CTRL, 32'h100);
        pswl_net_i.send(mq, 1'b1);
        rc(OFF_WAKE, 32'h700, 32'h0);
        pins(4'hf, 1'b0);
    endtask
    task automatic t_sleep;
        wr(OFF_PM_CTRL, 32'h101);
        rc(OFF_PM_CTRL, 32'h3, 32'h0);
        eeprom_config_word <= 16'h0600;
        wr(OFF_PM_CTRL, 32'h102);
        rc(OFF_PM_CTRL, 32'h3, 32'h2);
        wr(OFF_PM_CTRL, 32'h101);
        pins(4'h8, 1'b0);
        rc(OFF_PM_CTRL, 32'h3, 32'h1);
        pswl_net_i.send(mq, 1'b0);
        rc(OFF_WAKE, 32'h700, 32'h0);
        pswl_net_i.send(mq, 1'b1);
        rc(OFF_WAKE, 32'h700, 32'h200);
        rc(OFF_PM_CTRL, 32'h8000, 32'h8000);
        pins(4'h8, 1'b1);
        wr(OFF_PM_CTRL, 32'h1);
        pins(4'h8, 1'b0);
    endtask
    task automatic t_pattern;
        logic [7:0]  p[$];
        logic [31:0] c;
        c = crc({8'ha1, 8'hb2});
        p = {8'h01, 8'h02, 8'h00, c[7:0], c[15:8], c[23:16], c[31:24]};
        wr(OFF_WAKE, 32'h701);
        wr(OFF_PM_CTRL, 32'h8101);
        wr(OFF_PAT_BASE, 32'h0);
        wr(OFF_PAT_ADDR, 32'h0);
        foreach (p[i]) wr(OFF_PAT_DATA, {24'h0, p[i]});
        pswl_net_i.send({8'h55, 8'ha1, 8'hb2, 8'hc3}, 1'b0);
        rc(OFF_WAKE, 32'h700, 32'h0);
        pswl_net_i.send({8'h55, 8'ha1, 8'hb2, 8'hc3}, 1'b1);
        rc(OFF_WAKE, 32'h700, 32'h100);
        pins(4'h8, 1'b1);
    endtask
    task automatic t_link_off;
        wr(OFF_WAKE, 32'h704);
        wr(OFF_PM_CTRL, 32'h8101);
        pswl_net_i.link_up <= 1'b0;
        repeat (3) @(posedge mclk);
        rc(OFF_WAKE, 32'h700, 32'h400);
        pins(4'h8, 1'b1);
        wr(OFF_PM_CTRL, 32'h3);
        rc(OFF_CMD, 32'h77, 32'h40);
        rc(OFF_PM_CTRL, 32'h3, 32'h3);
        pins(4'h8, 1'b0);
        wr(OFF_PM_CTRL, 32'h0);
        rc(OFF_CMD, 32'h70, 32'h0);
    endtask
    // Pass 0 uses forced configuration, pass 1 the remote wake mode.
    task automatic t_forced;
        for (int k = 0; k < 2; k++) begin
            forced_config <= (k == 0);
            wr(OFF_WAKE, (k == 0) ? 32'h0 : 32'h8);
            sys_rst <= 1'b1;
            repeat (2) @(posedge mclk);
            sys_rst <= 1'b0;
            repeat (3) @(posedge mclk);
            rc(OFF_CMD, 32'h70, 32'h10);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence: reset, station address, then the scenarios.
    initial begin
        mq = {8'h00};
        repeat (6) mq.push_back(8'hff);
        repeat (16) for (int i = 5; i >= 0; i--) mq.push_back(MACV[8*i +: 8]);
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        aux_rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        wr(OFF_MAC_HI, {16'h0, MACV[47:32]});
        wr(OFF_MAC_LO, MACV[31:0]);
        t_active();
        t_sleep();
        t_pattern();
        t_link_off();
        t_forced();
        final_report();
    end
    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        final_report();
    end
endmodule
`default_nettype wire
